//--- rctt_pkg.sv
// Constants shared by the reload/capture/toggle timer files.
// Assumes an 8-bit special-function register port and one system clock.
package rctt_pkg;

   // Register offsets on the special-function register port
   localparam logic [7:0] RCTT_ADDR_CONTROL  = 8'hC8;
   localparam logic [7:0] RCTT_ADDR_CONFIG   = 8'hC9;
   localparam logic [7:0] RCTT_ADDR_RCAP_LO  = 8'hCA;
   localparam logic [7:0] RCTT_ADDR_RCAP_HI  = 8'hCB;
   localparam logic [7:0] RCTT_ADDR_COUNT_LO = 8'hCC;
   localparam logic [7:0] RCTT_ADDR_COUNT_HI = 8'hCD;

   // timer_control field positions
   localparam int RCTT_CN_WRAP_FLAG  = 7;
   localparam int RCTT_CN_EXT_FLAG   = 6;
   localparam int RCTT_CN_EXT_ENABLE = 3;
   localparam int RCTT_CN_RUN        = 2;
   localparam int RCTT_CN_CT_SELECT  = 1;
   localparam int RCTT_CN_CAPTURE    = 0;

   // timer_configuration field positions
   localparam int RCTT_CF_MODE_HI    = 4;
   localparam int RCTT_CF_MODE_LO    = 3;
   localparam int RCTT_CF_TOGGLE     = 2;
   localparam int RCTT_CF_OUT_ENABLE = 1;
   localparam int RCTT_CF_DOWN_EN    = 0;

   localparam logic [7:0]  RCTT_RESET_BYTE = 8'h00;
   localparam logic [15:0] RCTT_RESET_WORD = 16'h0000;
   localparam logic [15:0] RCTT_ALL_ONES   = 16'hFFFF;
   localparam logic [15:0] RCTT_ZERO       = 16'h0000;

   // Clock-mode field encodings
   typedef enum logic [1:0] {
      RCTT_CLK_DIV12 = 2'h0,
      RCTT_CLK_FULL  = 2'h1,
      RCTT_CLK_EXT8  = 2'h2,
      RCTT_CLK_DIV2  = 2'h3
   } rctt_clk_mode_t;

   // Prescaler terminal counts (divide ratio minus one)
   localparam logic [3:0] RCTT_DIV12_LAST = 4'hB;
   localparam logic [2:0] RCTT_EXT8_LAST  = 3'h7;

   // Synchronised pin indices
   localparam int RCTT_PIN_COUNT   = 0;
   localparam int RCTT_PIN_TRIGGER = 1;
   localparam int RCTT_PIN_EXTCLK  = 2;
   localparam int RCTT_PIN_NUM     = 3;

endpackage : rctt_pkg

//--- rctt_pin_sync.sv
// Two-flop synchronisers and falling- and rising-edge detectors for the timer's pins.
// Assumes the pins are asynchronous to i_clock.
`timescale 1ns/1ps
`default_nettype none
module rctt_pin_sync
   import rctt_pkg::*;
#(
   parameter int N = RCTT_PIN_NUM
) (
   input  wire logic         i_clock,
   input  wire logic         i_rst_n,
   input  wire logic [N-1:0] i_pins,
   output logic      [N-1:0] o_level,
   output logic      [N-1:0] o_fall,
   output logic      [N-1:0] o_rise
);
   logic [N-1:0] meta;
   logic [N-1:0] prev;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_pin
         // meta feeds only o_level, never the edge logic
         always_ff @(posedge i_clock) begin
            if (!i_rst_n) begin
               meta[g]    <= 1'b1;
               o_level[g] <= 1'b1;
               prev[g]    <= 1'b1;
            end else begin
               meta[g]    <= i_pins[g];
               o_level[g] <= meta[g];
               prev[g]    <= o_level[g];
            end
         end
         assign o_fall[g] = prev[g] & ~o_level[g];
         assign o_rise[g] = ~prev[g] & o_level[g];
      end
   endgenerate
endmodule : rctt_pin_sync
`default_nettype wire

//--- rctt_prescale.sv
// Timer-clock prescaler: one-cycle enable pulses at the chosen rate.
// Assumes i_ext_rise is already synchronised to i_clock.
`timescale 1ns/1ps
`default_nettype none
module rctt_prescale
   import rctt_pkg::*;
(
   input  wire logic           i_clock,
   input  wire logic           i_rst_n,
   input  wire rctt_clk_mode_t i_mode,
   input  wire logic           i_ext_rise,
   output logic                o_tick
);
   logic [3:0] div12;
   logic       div2;
   logic [2:0] ext8;
   logic       next_tick;

   wire div12_end = (div12 == RCTT_DIV12_LAST);
   wire ext8_end  = i_ext_rise && (ext8 == RCTT_EXT8_LAST);

   always_comb begin
      case (i_mode)
         RCTT_CLK_DIV12: next_tick = div12_end;
         RCTT_CLK_FULL:  next_tick = 1'b1;
         RCTT_CLK_EXT8:  next_tick = ext8_end;
         RCTT_CLK_DIV2:  next_tick = div2;
         default:        next_tick = 1'b0;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         div12  <= '0;
         div2   <= 1'b0;
         ext8   <= '0;
         o_tick <= 1'b0;
      end else begin
         div12  <= div12_end ? '0 : div12 + 4'h1;
         div2   <= ~div2;
         if (i_ext_rise)
            ext8 <= ext8 + 3'h1;
         o_tick <= next_tick;
      end
   end
endmodule : rctt_prescale
`default_nettype wire

//--- rctt_timer.sv
// 16-bit counter/timer with auto-reload, capture, up/down count and toggle output.
// Assumes an 8-bit register port on i_clock; all pins arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Toggle output inverts on each overflow or underflow, giving equal high and low.
// - Down-count reload mode: underflow when counter equals reload, then load all ones.
// - Up-count reload mode: overflow past all ones loads the reload value.
// - Reload mode, timer function, output enabled: run bit starts the toggling.
// - Toggle-state bit reads the output level; writing forces the output.
// - Wrap flag set on up wrap or down underflow; sticky until software clears.
// - External flag set by trigger falling edge capture or reload; software clears.
// - External enable clear: trigger pin ignored for capture, reload and direction.
// - Capture mode: trigger falling edge copies counter into reload/capture pair.
// - Reload mode, down-count off: trigger falling edge reloads and sets external flag.
// - Down-count off counts up; on, trigger low counts down, high counts up.
// - Run bit stops the counter at 0, lets it count at 1.
// - Timer function counts prescaled clock; counter function counts count-pin falling edges.
// - Capture/reload select: 0 auto-reload, 1 capture.
// - Clock mode: 00 div12, 01 undivided, 10 external div8 synced, 11 div2.
// - Output enable keeps toggle off the pin at 0, drives it at 1.
// - Reload/capture pair takes captures in capture mode, supplies reload otherwise.
// - Toggle output exists only on instances built with it enabled.
// - Down-count on: trigger pin sets direction only, no reload, no event.
module rctt_timer
   import rctt_pkg::*;
#(
   parameter bit HAS_TOGGLE = 1'b1
) (
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   input  wire logic [7:0] i_sfr_addr,
   input  wire logic       i_sfr_wr,
   input  wire logic [7:0] i_sfr_wdata,
   input  wire logic       i_sfr_rd,
   output logic      [7:0] o_sfr_rdata,
   input  wire logic       i_count_pin,
   input  wire logic       i_trigger_pin,
   input  wire logic       i_ext_clock,
   output logic            o_toggle_out,
   output logic            o_toggle_oe,
   output logic            o_wrap_flag,
   output logic            o_external_event_flag
);
   // Register bits: control, configuration, reload/capture pair and counter
   logic        external_trigger_enable;
   logic        run_control;
   logic        counter_timer_select;
   logic        capture_reload_select;
   logic [1:0]  clock_mode;
   logic        toggle_output_enable;
   logic        down_count_enable;
   logic        toggle_state;
   logic [15:0] reload_capture;
   logic [15:0] count;

   // Pin synchronisation
   logic [RCTT_PIN_NUM-1:0] pin_level;
   logic [RCTT_PIN_NUM-1:0] pin_fall;
   logic [RCTT_PIN_NUM-1:0] pin_rise;
   logic                    presc_tick;

   rctt_pin_sync #(.N(RCTT_PIN_NUM)) u_sync (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_pins  ({i_ext_clock, i_trigger_pin, i_count_pin}),
      .o_level (pin_level),
      .o_fall  (pin_fall),
      .o_rise  (pin_rise)
   );

   rctt_prescale u_presc (
      .i_clock    (i_clock),
      .i_rst_n    (i_rst_n),
      .i_mode     (rctt_clk_mode_t'(clock_mode)),
      .i_ext_rise (pin_rise[RCTT_PIN_EXTCLK]),
      .o_tick     (presc_tick)
   );

   // Register port decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   wire wr_cn  = i_sfr_wr && hit(i_sfr_addr, RCTT_ADDR_CONTROL);
   wire wr_cf  = i_sfr_wr && hit(i_sfr_addr, RCTT_ADDR_CONFIG);
   wire wr_rcl = i_sfr_wr && hit(i_sfr_addr, RCTT_ADDR_RCAP_LO);
   wire wr_rch = i_sfr_wr && hit(i_sfr_addr, RCTT_ADDR_RCAP_HI);
   wire wr_cl  = i_sfr_wr && hit(i_sfr_addr, RCTT_ADDR_COUNT_LO);
   wire wr_ch  = i_sfr_wr && hit(i_sfr_addr, RCTT_ADDR_COUNT_HI);
   wire wr_cnt = wr_cl || wr_ch;
   wire wr_rc  = wr_rcl || wr_rch;

   // Count enable and direction
   wire count_tick = counter_timer_select ? pin_fall[RCTT_PIN_COUNT] : presc_tick;
   wire advance    = run_control && count_tick;
   // Direction follows the pin only when both enables allow it
   wire count_down = down_count_enable && external_trigger_enable
                     && !pin_level[RCTT_PIN_TRIGGER];

   // Trigger edge acts only with external enable set and down-count off
   wire ext_evt   = external_trigger_enable && !down_count_enable
                    && pin_fall[RCTT_PIN_TRIGGER];
   wire ext_cap   = ext_evt && capture_reload_select;
   wire ext_load  = ext_evt && !capture_reload_select;

   wire at_ones   = (count == RCTT_ALL_ONES);
   wire at_zero   = (count == RCTT_ZERO);
   wire at_reload = (count == reload_capture);

   // Wrap detection for both modes and both directions
   wire wrap_up   = advance && !count_down && at_ones;
   wire wrap_dn   = advance && count_down
                    && (capture_reload_select ? at_zero : at_reload);
   wire wrap_evt  = wrap_up || wrap_dn;

   logic [15:0] next_count;
   always_comb begin
      next_count = count;
      if (ext_load)
         next_count = reload_capture;
      else if (wrap_up && !capture_reload_select)
         next_count = reload_capture;
      else if (wrap_dn && !capture_reload_select)
         next_count = RCTT_ALL_ONES;
      else if (advance && count_down)
         next_count = count - 16'h0001;
      else if (advance)
         next_count = count + 16'h0001;
      if (wr_cl)
         next_count[7:0] = i_sfr_wdata;
      if (wr_ch)
         next_count[15:8] = i_sfr_wdata;
   end

   logic [15:0] next_reload;
   always_comb begin
      next_reload = reload_capture;
      if (wr_rcl)
         next_reload[7:0] = i_sfr_wdata;
      if (wr_rch)
         next_reload[15:8] = i_sfr_wdata;
      // A capture in the same cycle as a software write wins
      if (ext_cap)
         next_reload = count;
   end

   // Hardware set wins over a software clear in the same cycle
   wire next_wrap_flag = wrap_evt || (wr_cn ? i_sfr_wdata[RCTT_CN_WRAP_FLAG] : o_wrap_flag);
   wire next_ext_flag  = ext_evt
                         || (wr_cn ? i_sfr_wdata[RCTT_CN_EXT_FLAG] : o_external_event_flag);

   // Toggle flips on each wrap; a software write forces the level
   wire next_toggle = !HAS_TOGGLE ? 1'b0 :
                      wr_cf ? i_sfr_wdata[RCTT_CF_TOGGLE] :
                      wrap_evt ? !toggle_state : toggle_state;

   function automatic logic [7:0] read_mux(input logic [7:0] a);
      logic [7:0] v;
      v = RCTT_RESET_BYTE;
      case (a)
         RCTT_ADDR_CONTROL: begin
            v[RCTT_CN_WRAP_FLAG]  = o_wrap_flag;
            v[RCTT_CN_EXT_FLAG]   = o_external_event_flag;
            v[RCTT_CN_EXT_ENABLE] = external_trigger_enable;
            v[RCTT_CN_RUN]        = run_control;
            v[RCTT_CN_CT_SELECT]  = counter_timer_select;
            v[RCTT_CN_CAPTURE]    = capture_reload_select;
         end
         RCTT_ADDR_CONFIG: begin
            v[RCTT_CF_MODE_HI]    = clock_mode[1];
            v[RCTT_CF_MODE_LO]    = clock_mode[0];
            v[RCTT_CF_TOGGLE]     = toggle_state;
            v[RCTT_CF_OUT_ENABLE] = toggle_output_enable;
            v[RCTT_CF_DOWN_EN]    = down_count_enable;
         end
         RCTT_ADDR_RCAP_LO:  v = reload_capture[7:0];
         RCTT_ADDR_RCAP_HI:  v = reload_capture[15:8];
         RCTT_ADDR_COUNT_LO: v = count[7:0];
         RCTT_ADDR_COUNT_HI: v = count[15:8];
         default:            v = RCTT_RESET_BYTE;
      endcase
      return v;
   endfunction

   // A process wakes on the registers the function reads, not only on the address
   logic [7:0] rd_value;
   always_comb rd_value = read_mux(i_sfr_addr);

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         external_trigger_enable <= 1'b0;
         run_control             <= 1'b0;
         counter_timer_select    <= 1'b0;
         capture_reload_select   <= 1'b0;
      end else if (wr_cn) begin
         external_trigger_enable <= i_sfr_wdata[RCTT_CN_EXT_ENABLE];
         run_control             <= i_sfr_wdata[RCTT_CN_RUN];
         counter_timer_select    <= i_sfr_wdata[RCTT_CN_CT_SELECT];
         capture_reload_select   <= i_sfr_wdata[RCTT_CN_CAPTURE];
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         clock_mode           <= 2'h0;
         toggle_output_enable <= 1'b0;
         down_count_enable    <= 1'b0;
      end else if (wr_cf) begin
         clock_mode           <= {i_sfr_wdata[RCTT_CF_MODE_HI], i_sfr_wdata[RCTT_CF_MODE_LO]};
         toggle_output_enable <= HAS_TOGGLE && i_sfr_wdata[RCTT_CF_OUT_ENABLE];
         down_count_enable    <= i_sfr_wdata[RCTT_CF_DOWN_EN];
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         count                 <= RCTT_RESET_WORD;
         reload_capture        <= RCTT_RESET_WORD;
         o_wrap_flag           <= 1'b0;
         o_external_event_flag <= 1'b0;
         toggle_state          <= 1'b0;
         o_sfr_rdata           <= RCTT_RESET_BYTE;
      end else begin
         count                 <= next_count;
         reload_capture        <= next_reload;
         o_wrap_flag           <= next_wrap_flag;
         o_external_event_flag <= next_ext_flag;
         toggle_state          <= next_toggle;
         if (i_sfr_rd)
            o_sfr_rdata <= rd_value;
      end
   end

   // The pin carries the toggle level only while output enable is set
   assign o_toggle_out = toggle_state;
   assign o_toggle_oe  = toggle_output_enable;

   // Checks
   sequence s_wrap_clean;
      wrap_evt && !wr_cf;
   endsequence

   sequence s_down_underflow;
      advance && count_down && !capture_reload_select && at_reload && !ext_load && !wr_cnt;
   endsequence

   sequence s_up_overflow;
      advance && !count_down && !capture_reload_select && at_ones && !ext_load && !wr_cnt;
   endsequence

   sequence s_up_step;
      advance && !count_down && !at_ones && !ext_load && !wr_cnt;
   endsequence

   sequence s_down_step;
      advance && count_down && !wrap_dn && !ext_load && !wr_cnt;
   endsequence

   toggle_flip_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_wrap_clean |=> (toggle_state == (HAS_TOGGLE && !$past(toggle_state))))
      else $error("toggle did not flip on wrap");

   down_reload_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_down_underflow |=> (count == RCTT_ALL_ONES) && o_wrap_flag)
      else $error("down underflow did not load all ones");

   up_reload_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_up_overflow |=> (count == $past(reload_capture)) && o_wrap_flag)
      else $error("up overflow did not load reload value");

   flag_sticky_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_wrap_flag && !wr_cn |=> o_wrap_flag)
      else $error("wrap flag cleared without software");

   ext_flag_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ext_evt |=> o_external_event_flag ##1 (o_external_event_flag || $past(wr_cn)))
      else $error("external flag not set or lost");

   ext_ignore_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !external_trigger_enable && !wr_cn
      |=> (o_external_event_flag == $past(o_external_event_flag)))
      else $error("trigger pin acted while disabled");

   dir_ignore_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !external_trigger_enable && advance && !at_ones && !wr_cnt
      |=> (count == $past(count) + 16'h0001))
      else $error("trigger pin steered direction while disabled");

   capture_copy_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ext_cap |=> (reload_capture == $past(count)))
      else $error("capture did not copy counter");

   ext_reload_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ext_load && !wr_cnt |=> (count == $past(reload_capture)))
      else $error("trigger edge did not reload counter");

   run_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      !run_control && !wr_cnt && !ext_load |=> (count == $past(count)))
      else $error("counter moved while stopped");

   no_dcen_event_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      down_count_enable && !wr_cn
      |=> (o_external_event_flag == $past(o_external_event_flag)))
      else $error("trigger event while down-count enabled");

   oe_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      wr_cf |=> (o_toggle_oe == (HAS_TOGGLE && $past(i_sfr_wdata[RCTT_CF_OUT_ENABLE]))))
      else $error("output enable does not follow register");

   up_step_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_up_step |=> (count == $past(count) + 16'h0001))
      else $error("counter did not step up");

   down_step_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      s_down_step |=> (count == $past(count) - 16'h0001))
      else $error("counter did not step down");

   wrap_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      wrap_evt |=> o_wrap_flag)
      else $error("wrap flag not set on wrap");

   toggle_force_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      wr_cf |=> (toggle_state == (HAS_TOGGLE && $past(i_sfr_wdata[RCTT_CF_TOGGLE]))))
      else $error("toggle write did not force level");

   read_toggle_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      i_sfr_rd && (i_sfr_addr == RCTT_ADDR_CONFIG)
      |=> (o_sfr_rdata[RCTT_CF_TOGGLE] == $past(toggle_state)))
      else $error("toggle read does not show level");

   count_pin_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      counter_timer_select && !pin_fall[RCTT_PIN_COUNT] && !wr_cnt && !ext_load
      |=> (count == $past(count)))
      else $error("counter moved without count pin edge");

   full_rate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (clock_mode == RCTT_CLK_FULL) |=> presc_tick)
      else $error("undivided clock missed a tick");

   half_rate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (clock_mode == RCTT_CLK_DIV2) && ($past(clock_mode) == RCTT_CLK_DIV2) && presc_tick
      |=> !presc_tick)
      else $error("half-rate clock ticked twice in a row");

   capture_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      ext_cap && !advance && !wr_cnt |=> (count == $past(count)))
      else $error("capture disturbed the counter");

endmodule : rctt_timer
`default_nettype wire

//--- rctt_pin_model.sv
// Far-side pin model: trigger, count and oscillator pins, toggle pin observer.
// Assumes the bench calls its tasks; trigger and count pins change 2 ns after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module rctt_pin_model (
   input  wire logic i_clock,
   input  wire logic i_toggle_out,
   input  wire logic i_toggle_oe,
   output logic      o_count_pin,
   output logic      o_trigger_pin,
   output logic      o_ext_clock
);
   logic pin_level;
   int   n_edges;
   // Released pin floats to its pull-up level
   assign pin_level = i_toggle_oe ? i_toggle_out : 1'b1;
   always @(pin_level) n_edges++;
   initial begin
      o_count_pin   = 1'b1;
      o_trigger_pin = 1'b1;
      o_ext_clock   = 1'b0;
      n_edges       = 0;
      // Oscillator runs free, six system clocks a period, no phase tie
      forever #75 o_ext_clock = ~o_ext_clock;
   end
   // Trigger levels held four clocks, count-pin levels three, so the synchronisers see every change
   task automatic drive_trigger(input logic level);
      @(posedge i_clock);
      #2 o_trigger_pin = level;
      repeat (4) @(posedge i_clock);
   endtask : drive_trigger
   task automatic pulse_count(input int n);
      repeat (n) begin
         @(posedge i_clock);
         #2 o_count_pin = 1'b0;
         repeat (3) @(posedge i_clock);
         #2 o_count_pin = 1'b1;
         repeat (3) @(posedge i_clock);
      end
   endtask : pulse_count
endmodule : rctt_pin_model
`default_nettype wire

//--- tb_reload_capture_timer_toggle.sv
// Self-checking bench for the reload/capture/toggle timer.
// Assumes rctt_pkg, rctt_timer and rctt_pin_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
   $display("[ERR] %s expected %h seen %h", nm, exp, got); failures++; end end
module tb_reload_capture_timer_toggle;
   import rctt_pkg::*;
   logic       clock, rst_n, wr_s, rd_s, count_pin, trig_pin, ext_clk;
   logic       tog, oe, wflag, eflag, tog_nt, oe_nt, wflag_nt, eflag_nt;
   logic [7:0] addr, wdata, rdata, rdata_nt, rv, rv_nt;
   int         failures, n_compared;

   rctt_timer #(.HAS_TOGGLE(1'b1)) dut_u (.i_clock(clock), .i_rst_n(rst_n),
      .i_sfr_addr(addr), .i_sfr_wr(wr_s), .i_sfr_wdata(wdata), .i_sfr_rd(rd_s),
      .o_sfr_rdata(rdata), .i_count_pin(count_pin), .i_trigger_pin(trig_pin),
      .i_ext_clock(ext_clk), .o_toggle_out(tog), .o_toggle_oe(oe),
      .o_wrap_flag(wflag), .o_external_event_flag(eflag));
   rctt_timer #(.HAS_TOGGLE(1'b0)) dut_u_notog (.i_clock(clock), .i_rst_n(rst_n),
      .i_sfr_addr(addr), .i_sfr_wr(wr_s), .i_sfr_wdata(wdata), .i_sfr_rd(rd_s),
      .o_sfr_rdata(rdata_nt), .i_count_pin(count_pin), .i_trigger_pin(trig_pin),
      .i_ext_clock(ext_clk), .o_toggle_out(tog_nt), .o_toggle_oe(oe_nt),
      .o_wrap_flag(wflag_nt), .o_external_event_flag(eflag_nt));
   rctt_pin_model pm_u (.i_clock(clock), .i_toggle_out(tog), .i_toggle_oe(oe),
      .o_count_pin(count_pin), .o_trigger_pin(trig_pin), .o_ext_clock(ext_clk));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #2 addr = a;
      wdata = d;
      wr_s = 1'b1;
      @(posedge clock);
      #2 wr_s = 1'b0;
   endtask : wr
   // Read data is sampled a full cycle late; it stands until the next read
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      #2 addr = a;
      rd_s = 1'b1;
      @(posedge clock);
      #2 rd_s = 1'b0;
      @(posedge clock);
      #2 rv = rdata;
      rv_nt = rdata_nt;
   endtask : rd
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      rd(a);
      `CHK(nm, e, rv)
   endtask : chk_rd
   task automatic trig_fall;
      pm_u.drive_trigger(1'b0);
      pm_u.drive_trigger(1'b1);
   endtask : trig_fall
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task automatic wait_wrap;
      for (int k = 0; k < 200 && wflag !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      if (wflag !== 1'b1) begin
         $display("[ERR] wrap wait timed out");
         failures++;
         tally_and_finish();
      end
   endtask : wait_wrap

   task automatic t_reset;
      for (logic [8:0] a = 9'h0C8; a <= 9'h0CD; a++) chk_rd(a[7:0], RCTT_RESET_BYTE, "reset");
      chk_rd(8'hD0, 8'h00, "unmapped");
      $display("test reset done");
   endtask : t_reset

   task automatic t_up_toggle;
      int n0;
      wr(RCTT_ADDR_RCAP_LO, 8'h00);
      wr(RCTT_ADDR_RCAP_HI, 8'h80);
      wr(RCTT_ADDR_COUNT_LO, 8'hFD);
      wr(RCTT_ADDR_COUNT_HI, 8'hFF);
      wr(RCTT_ADDR_CONFIG, 8'h0A);
      n0 = pm_u.n_edges;
      wr(RCTT_ADDR_CONTROL, 8'h04);
      wait_wrap();
      wr(RCTT_ADDR_CONTROL, 8'h80);
      `CHK("toggle level", 1'b1, tog)
      `CHK("toggle enable", 1'b1, oe)
      `CHK("pin edges", 1, pm_u.n_edges - n0)
      chk_rd(RCTT_ADDR_COUNT_HI, 8'h80, "count after wrap");
      chk_rd(RCTT_ADDR_CONTROL, 8'h80, "wrap flag");
      chk_rd(RCTT_ADDR_CONFIG, 8'h0E, "toggle state");
      `CHK("plain config", 8'h08, rv_nt)
      `CHK("plain toggle", 1'b0, tog_nt)
      `CHK("plain enable", 1'b0, oe_nt)
      `CHK("plain wrap flag", 1'b1, wflag_nt)
      $display("test up_toggle done");
   endtask : t_up_toggle

   task automatic t_force;
      wr(RCTT_ADDR_CONFIG, 8'h02);
      `CHK("forced low", 1'b0, tog)
      wr(RCTT_ADDR_CONFIG, 8'h04);
      `CHK("forced high", 1'b1, tog)
      `CHK("enable off", 1'b0, oe)
      chk_rd(RCTT_ADDR_CONFIG, 8'h04, "forced state");
      $display("test force done");
   endtask : t_force

   task automatic t_down;
      wr(RCTT_ADDR_CONTROL, 8'h08);
      wr(RCTT_ADDR_CONFIG, 8'h09);
      wr(RCTT_ADDR_RCAP_LO, 8'h00);
      wr(RCTT_ADDR_RCAP_HI, 8'h01);
      wr(RCTT_ADDR_COUNT_LO, 8'h04);
      wr(RCTT_ADDR_COUNT_HI, 8'h01);
      pm_u.drive_trigger(1'b0);
      wr(RCTT_ADDR_CONTROL, 8'h0C);
      wait_wrap();
      wr(RCTT_ADDR_CONTROL, 8'h88);
      chk_rd(RCTT_ADDR_COUNT_HI, 8'hFF, "count after underflow");
      `CHK("no trigger event", 1'b0, eflag)
      pm_u.drive_trigger(1'b1);
      $display("test down done");
   endtask : t_down

   task automatic t_capture;
      wr(RCTT_ADDR_CONFIG, 8'h00);
      wr(RCTT_ADDR_CONTROL, 8'h09);
      wr(RCTT_ADDR_COUNT_LO, 8'h34);
      wr(RCTT_ADDR_COUNT_HI, 8'h12);
      trig_fall();
      chk_rd(RCTT_ADDR_RCAP_LO, 8'h34, "capture low");
      chk_rd(RCTT_ADDR_RCAP_HI, 8'h12, "capture high");
      chk_rd(RCTT_ADDR_COUNT_HI, 8'h12, "count kept");
      `CHK("external flag", 1'b1, eflag)
      `CHK("plain external flag", 1'b1, eflag_nt)
      wr(RCTT_ADDR_CONTROL, 8'h01);
      `CHK("flag cleared", 1'b0, eflag)
      wr(RCTT_ADDR_COUNT_LO, 8'h55);
      trig_fall();
      chk_rd(RCTT_ADDR_RCAP_LO, 8'h34, "capture ignored");
      `CHK("flag ignored", 1'b0, eflag)
      $display("test capture done");
   endtask : t_capture

   task automatic t_reload_trigger;
      wr(RCTT_ADDR_CONTROL, 8'h08);
      wr(RCTT_ADDR_RCAP_LO, 8'hCD);
      wr(RCTT_ADDR_RCAP_HI, 8'hAB);
      wr(RCTT_ADDR_COUNT_LO, 8'h00);
      wr(RCTT_ADDR_COUNT_HI, 8'h00);
      trig_fall();
      chk_rd(RCTT_ADDR_COUNT_LO, 8'hCD, "reload low");
      chk_rd(RCTT_ADDR_COUNT_HI, 8'hAB, "reload high");
      `CHK("reload flag", 1'b1, eflag)
      wr(RCTT_ADDR_CONTROL, 8'h00);
      $display("test reload_trigger done");
   endtask : t_reload_trigger

   task automatic t_counter_fn;
      wr(RCTT_ADDR_COUNT_LO, 8'h00);
      wr(RCTT_ADDR_CONTROL, 8'h06);
      pm_u.pulse_count(3);
      wr(RCTT_ADDR_CONTROL, 8'h00);
      chk_rd(RCTT_ADDR_COUNT_LO, 8'h03, "count pin edges");
      $display("test counter_fn done");
   endtask : t_counter_fn

   task automatic t_clock_modes;
      // Divisors for 00, 01, 10, 11; external is 8 periods of six clocks
      int         divs[4] = '{12, 1, 48, 2};
      int         e;
      logic [7:0] held;
      for (int i = 0; i < 4; i++) begin
         wr(RCTT_ADDR_COUNT_LO, 8'h00);
         wr(RCTT_ADDR_CONFIG, {3'h0, i[1:0], 3'h0});
         wr(RCTT_ADDR_CONTROL, 8'h04);
         cyc(240);
         wr(RCTT_ADDR_CONTROL, 8'h00);
         rd(RCTT_ADDR_COUNT_LO);
         e = 240 / divs[i];
         `CHK("mode count", 1'b1, (int'(rv) >= e && int'(rv) <= e + 2))
      end
      held = rv;
      cyc(20);
      rd(RCTT_ADDR_COUNT_LO);
      `CHK("stopped count", held, rv)
      $display("test clock_modes done");
   endtask : t_clock_modes

   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr_s = 1'b0;
      rd_s = 1'b0;
      failures = 0;
      n_compared = 0;
      cyc(10);
      #2 rst_n = 1'b1;
      t_reset();
      t_up_toggle();
      t_force();
      t_down();
      t_capture();
      t_reload_trigger();
      t_counter_fn();
      t_clock_modes();
      tally_and_finish();
   end
endmodule : tb_reload_capture_timer_toggle
`default_nettype wire
